/* File: logic/power_good_debounce_polarity.sv */
// power-good sequencing, fault flag output and pin polarity with an Avalon-MM register slave
// assumes fault qualifiers are synchronous to mclk; request and flag pins are asynchronous
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Functional notes
// - bits 7:4 select power-good delay: 0000=320ms, 0101=200ms, 1010=600ms, 1111=none.
// - power-good stays low until all supply checks are normal for the delay.
// - after power-on request goes inactive, wait the delay before dropping power-good.
// - bit 3 low: any flag sets flag output; high: only non-ignored flags.
// - bit 2 high makes the external flag input active low, else active high.
// - bit 1 high drives the or-ing transistor output active low, else active high.
// - bit 0 high makes the power-on request input active low, else active high.
module power_good_debounce_polarity
	import pg_cfg_pkg::*;
#(
	parameter int unsigned DLY_A = pg_cfg_pkg::DLY_A_CYC,
	parameter int unsigned DLY_B = pg_cfg_pkg::DLY_B_CYC,
	parameter int unsigned DLY_C = pg_cfg_pkg::DLY_C_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	// Avalon-MM slave, byte addresses
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// pins
	input wire logic power_on_request_in,
	input wire logic external_flag_in,
	// fault qualifiers from other units, high = fault except supply_ok, which is high = good
	input wire logic supply_ok,
	input wire logic ocp_fast_primary,
	input wire logic ocp_acc_primary,
	input wire logic ocp_acc_secondary,
	input wire logic uvp_fault,
	input wire logic ovp_local_fault,
	input wire logic ovp_load_fault,
	output logic power_good_primary_out,
	output logic fault_flag_out,
	output logic oring_transistor_out,
	output logic irq
);
	import pg_cfg_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [CNT_W-1:0] dly_cycles(input logic [3:0] sel);
		logic [CNT_W-1:0] c;
		c = CNT_W'(DLY_A);
		if (sel == DBN_200) begin
			c = CNT_W'(DLY_B);
		end else if (sel == DBN_600) begin
			c = CNT_W'(DLY_C);
		end else if (sel == DBN_ZERO) begin
			c = '0;
		end
		return c;
	endfunction

	function automatic logic [9:0] byte_addr(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction

	// ****************************************
	// input synchronisation and polarity
	// ****************************************
	// both asynchronous pins cross together; nothing reads the first flop
	logic [1:0] pin_q;
	pin_sync2 #(.W(2)) u_sync (
		.mclk(mclk),
		.rst(rst),
		.d({external_flag_in, power_on_request_in}),
		.q(pin_q)
	);

	logic [7:0] cfg_r;
	logic [7:0] ign_r;
	logic [3:0] en_r;
	logic [3:0] stat_r;
	logic [3:0] stat_nxt;

	wire power_on_request_in_act = pin_q[0] ^ cfg_r[POWER_ON_REQUEST_IN_POL_BIT];
	wire extf_act = pin_q[1] ^ cfg_r[EXTF_POL_BIT];
	wire [3:0] dbn_sel = cfg_r[DBN_HI:DBN_LO];
	wire [CNT_W-1:0] dly_now = dly_cycles(dbn_sel);
	// pattern 1111 bypasses the timer, which cannot count zero cycles
	wire dly_zero = (dly_now == '0);

	// ****************************************
	// fault qualification
	// ****************************************
	wire [7:0] flags = {
		extf_act,
		ovp_load_fault,
		ovp_local_fault,
		uvp_fault,
		ocp_acc_secondary,
		ocp_acc_primary,
		ocp_fast_primary,
		!supply_ok
	};
	wire checks_ok = (flags[6:0] == 7'h00);
	// the ignore mask only counts when the select bit is set
	wire [7:0] flags_eff = cfg_r[FLAG_SEL_BIT] ? (flags & ~ign_r) : flags;
	wire flag_nxt = |flags_eff;
	wire on_cond = power_on_request_in_act && checks_ok;

	// ****************************************
	// power-good sequencer
	// ****************************************
	delay_timer_if #(.W(CNT_W)) tif ();
	delay_timer #(.W(CNT_W)) u_tmr (
		.mclk(mclk),
		.rst(rst),
		.t(tif)
	);

	pg_state_t state_r;
	pg_state_t state_nxt;
	logic start_c;

	always_comb begin
		state_nxt = state_r;
		start_c = 1'b0;
		case (state_r)
			PG_OFF: begin
				if (on_cond && dly_zero) begin
					state_nxt = PG_ON;
				end else if (on_cond) begin
					state_nxt = PG_WAIT_ON;
					start_c = 1'b1;
				end
			end
			PG_WAIT_ON: begin
				// any check leaving normal limits restarts the whole wait
				if (!on_cond) begin
					state_nxt = PG_OFF;
				end else if (tif.expired) begin
					state_nxt = PG_ON;
				end
			end
			PG_ON: begin
				// a real fault drops power-good at once; only the request is debounced
				if (!checks_ok) begin
					state_nxt = PG_OFF;
				end else if (!power_on_request_in_act && dly_zero) begin
					state_nxt = PG_OFF;
				end else if (!power_on_request_in_act) begin
					state_nxt = PG_WAIT_OFF;
					start_c = 1'b1;
				end
			end
			PG_WAIT_OFF: begin
				if (!checks_ok) begin
					state_nxt = PG_OFF;
				end else if (power_on_request_in_act) begin
					state_nxt = PG_ON;
				end else if (tif.expired) begin
					state_nxt = PG_OFF;
				end
			end
			default: begin
				state_nxt = PG_OFF;
			end
		endcase
	end

	assign tif.start = start_c;
	assign tif.limit = dly_now;

	wire pg_nxt = (state_nxt == PG_ON) || (state_nxt == PG_WAIT_OFF);

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= PG_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ****************************************
	// pin outputs
	// ****************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			power_good_primary_out <= 1'b0;
			fault_flag_out <= 1'b0;
			oring_transistor_out <= 1'b0;
		end else begin
			power_good_primary_out <= pg_nxt;
			fault_flag_out <= flag_nxt;
			// transistor conducts while power-good is held
			oring_transistor_out <= pg_nxt ^ cfg_r[GATE_POL_BIT];
		end
	end

	// ****************************************
	// events and interrupt
	// ****************************************
	wire pg_q = power_good_primary_out;
	wire ev_pg_rise = !pg_q && pg_nxt;
	wire ev_pg_fall = pg_q && !pg_nxt;
	wire ev_flag_rise = flag_nxt && !fault_flag_out;
	// marks power-good lost to a failed check rather than to the request
	wire ev_fault_drop = pg_q && !checks_ok;
	logic [3:0] evt;
	always_comb begin
		evt = 4'h0;
		evt[EV_PG_RISE] = ev_pg_rise;
		evt[EV_PG_FALL] = ev_pg_fall;
		evt[EV_FLAG_RISE] = ev_flag_rise;
		evt[EV_FAULT_DROP] = ev_fault_drop;
	end

	// ****************************************
	// Avalon-MM slave
	// ****************************************
	// one wait cycle per access; the register is then taken on the waitrequest-low edge
	logic wait_r;
	wire req = read || write;
	wire take_wr = write && !wait_r;
	wire be0 = byteenable[0];
	wire hit_cfg = (address == byte_addr(IDX_CFG));
	wire hit_stat = (address == byte_addr(IDX_STAT));
	wire hit_clr = (address == byte_addr(IDX_CLR));
	wire hit_en = (address == byte_addr(IDX_EN));
	wire hit_live = (address == byte_addr(IDX_LIVE));
	wire hit_ign = (address == byte_addr(IDX_IGN));
	wire wr_cfg = take_wr && be0 && hit_cfg;
	wire wr_ign = take_wr && be0 && hit_ign;
	wire wr_en = take_wr && be0 && hit_en;
	wire wr_clr = take_wr && be0 && hit_clr;
	wire [3:0] clr_mask = wr_clr ? writedata[3:0] : 4'h0;
	wire [7:0] live = {
		3'b000,
		extf_act,
		power_on_request_in_act,
		checks_ok,
		fault_flag_out,
		pg_q
	};

	// write-only clear and unmapped indices read as zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_cfg) begin
			rd_mux = {24'h000000, cfg_r};
		end else if (hit_stat) begin
			rd_mux = {28'h0000000, stat_r};
		end else if (hit_en) begin
			rd_mux = {28'h0000000, en_r};
		end else if (hit_live) begin
			rd_mux = {24'h000000, live};
		end else if (hit_ign) begin
			rd_mux = {24'h000000, ign_r};
		end
	end

	// a new event outlives a clear in the same cycle
	assign stat_nxt = (stat_r & ~clr_mask) | evt;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_r <= 1'b1;
			readdata <= 32'h0000_0000;
		end else begin
			wait_r <= !(req && wait_r);
			readdata <= (read && wait_r) ? rd_mux : readdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_r <= CFG_RST;
			ign_r <= IGN_RST;
			en_r <= EVT_RST;
			stat_r <= EVT_RST;
			irq <= 1'b0;
		end else begin
			if (wr_cfg) begin
				cfg_r <= writedata[7:0];
			end
			if (wr_ign) begin
				ign_r <= writedata[7:0];
			end
			if (wr_en) begin
				en_r <= writedata[3:0];
			end
			stat_r <= stat_nxt;
			irq <= |(stat_nxt & en_r);
		end
	end

	assign waitrequest = wait_r;
endmodule // power_good_debounce_polarity

/* File: logic/pg_cfg_pkg.sv */
// power-good debounce and pin polarity block: shared constants
// assumes a 200 MHz system clock; register indices are word indices
package pg_cfg_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned CLK_KHZ = 200000;
	localparam int unsigned DLY_A_MS = 320;
	localparam int unsigned DLY_B_MS = 200;
	localparam int unsigned DLY_C_MS = 600;
	localparam int unsigned DLY_A_CYC = DLY_A_MS * CLK_KHZ;
	localparam int unsigned DLY_B_CYC = DLY_B_MS * CLK_KHZ;
	localparam int unsigned DLY_C_CYC = DLY_C_MS * CLK_KHZ;
	localparam int CNT_W = 27;

	// ****************************************
	// register map (index; byte address is index * 4)
	// ****************************************
	localparam logic [7:0] IDX_CFG = 8'h2D;
	localparam logic [7:0] IDX_STAT = 8'h30;
	localparam logic [7:0] IDX_CLR = 8'h31;
	localparam logic [7:0] IDX_EN = 8'h32;
	localparam logic [7:0] IDX_LIVE = 8'h33;
	localparam logic [7:0] IDX_IGN = 8'h34;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] IGN_RST = 8'h00;
	localparam logic [3:0] EVT_RST = 4'h0;

	// ****************************************
	// configuration fields
	// ****************************************
	localparam int DBN_HI = 7;
	localparam int DBN_LO = 4;
	localparam int FLAG_SEL_BIT = 3;
	localparam int EXTF_POL_BIT = 2;
	localparam int GATE_POL_BIT = 1;
	localparam int POWER_ON_REQUEST_IN_POL_BIT = 0;
	localparam logic [3:0] DBN_320 = 4'h0;
	localparam logic [3:0] DBN_200 = 4'h5;
	localparam logic [3:0] DBN_600 = 4'hA;
	localparam logic [3:0] DBN_ZERO = 4'hF;

	// ****************************************
	// event bits
	// ****************************************
	localparam int EV_PG_RISE = 0;
	localparam int EV_PG_FALL = 1;
	localparam int EV_FLAG_RISE = 2;
	localparam int EV_FAULT_DROP = 3;

	typedef enum logic [1:0] {
		PG_OFF = 2'b00,
		PG_WAIT_ON = 2'b01,
		PG_ON = 2'b10,
		PG_WAIT_OFF = 2'b11
	} pg_state_t;
endpackage

/* File: logic/delay_timer_if.sv */
// carrier between the power-good sequencer and its delay timer
// assumes both ends on the same clock
`timescale 1ns/1ps
interface delay_timer_if #(parameter int W = 27);
	logic start;
	logic [W-1:0] limit;
	logic expired;
	logic busy;
	modport ctrl (output start, output limit, input expired, input busy);
	modport tmr (input start, input limit, output expired, output busy);
endinterface // delay_timer_if

/* File: logic/pin_sync2.sv */
// two-flop synchroniser for pins arriving from outside the clock domain
// assumes inputs change slowly against the clock
`timescale 1ns/1ps
module pin_sync2 #(parameter int W = 2) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	always_ff @(posedge mclk) begin
		if (rst) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // pin_sync2

/* File: logic/delay_timer.sv */
// one-shot down counter: start loads limit, expired pulses at zero
// assumes limit is at least one cycle
`timescale 1ns/1ps
module delay_timer #(parameter int W = 27) (
	input wire logic mclk,
	input wire logic rst,
	delay_timer_if.tmr t
);
	logic [W-1:0] cnt_r;
	logic busy_r;
	logic exp_r;
	wire last = busy_r && (cnt_r == W'(1));
	assign t.busy = busy_r;
	assign t.expired = exp_r;
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_r <= '0;
			busy_r <= 1'b0;
			exp_r <= 1'b0;
		end else begin
			// a restart mid-count simply reloads
			cnt_r <= t.start ? t.limit : (busy_r ? cnt_r - W'(1) : cnt_r);
			busy_r <= t.start ? 1'b1 : (busy_r && !last);
			exp_r <= !t.start && last;
		end
	end
endmodule // delay_timer

/* File: bench/pg_port_checker.sv */
// checker: bus handshake, reset state and power-good fault timing
// assumes one mclk domain; bound onto the block
`timescale 1ns/1ps
module pg_port_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [9:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] readdata,
	input wire logic waitrequest,
	input wire logic supply_ok,
	input wire logic ocp_fast_primary,
	input wire logic ocp_acc_primary,
	input wire logic ocp_acc_secondary,
	input wire logic uvp_fault,
	input wire logic ovp_local_fault,
	input wire logic ovp_load_fault,
	input wire logic power_good_primary_out,
	input wire logic fault_flag_out,
	input wire logic oring_transistor_out,
	input wire logic irq
);
	wire ok = supply_ok && !(ocp_fast_primary || ocp_acc_primary || ocp_acc_secondary
		|| uvp_fault || ovp_local_fault || ovp_load_fault);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	chk_bus_grant: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("no grant");
	chk_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("grant too long");
	chk_grant_cause: assert property ($fell(waitrequest) |-> $past(read || write))
		else $error("grant unasked");
	chk_rdata_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
		else $error("readdata moved");
	chk_unmapped_zero: assert property (read && waitrequest && address == 10'h3FC
		|=> readdata == 32'h0) else $error("unmapped read");
	chk_reset_state: assert property ($fell(rst) |-> waitrequest && readdata == 32'h0
		&& !power_good_primary_out && !fault_flag_out && !oring_transistor_out && !irq)
		else $error("bad reset state");
	chk_fault_drop: assert property (power_good_primary_out && !ok |=> !power_good_primary_out)
		else $error("pg held in fault");
	chk_rise_ok: assert property ($rose(power_good_primary_out) |-> $past(ok))
		else $error("pg rose in fault");
	cover property ($rose(power_good_primary_out));
	cover property (power_good_primary_out && !ok);
	cover property ($rose(irq));
endmodule // pg_port_checker

bind power_good_debounce_polarity pg_port_checker u_chk (.mclk, .rst, .address, .read,
	.write, .readdata, .waitrequest, .supply_ok, .ocp_fast_primary, .ocp_acc_primary,
	.ocp_acc_secondary, .uvp_fault, .ovp_local_fault, .ovp_load_fault,
	.power_good_primary_out, .fault_flag_out, .oring_transistor_out, .irq);

/* File: bench/supervisor_model.sv */
// supervisor model: drives the power-on request pin
// assumes pol mirrors cfg bit 0 of the block
`timescale 1ns/1ps
module supervisor_model (
	input wire logic mclk,
	input wire logic want,
	input wire logic pol,
	output logic power_on_request_in
);
	initial power_on_request_in = 1'b0;
	always @(posedge mclk) begin
		power_on_request_in <= want ^ pol;
	end
endmodule // supervisor_model

/* File: bench/power_good_debounce_polarity_test.sv */
// bench: registers, power-good delays, polarity, flag output, interrupt
// assumes shortened delays and the supervisor model on the request pin
`timescale 1ns/1ps
module power_good_debounce_polarity_test;
	import pg_cfg_pkg::*;
	localparam int DA = 40;
	localparam int DB = 25;
	localparam int DC = 75;
	logic mclk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, want = 1'b0, pol = 1'b0;
	logic ext = 1'b0, waitrequest, power_on_request_in, pg, flag, gate, irq;
	logic [9:0] address = 10'h0;
	logic [3:0] byteenable = 4'hF;
	logic [6:0] flt = 7'h0;
	logic [31:0] writedata = 32'h0, readdata, rd, r, seed = 32'h03DB53C6;
	logic [3:0] pats [5] = '{4'hF, 4'h0, 4'h5, 4'hA, 4'h3};
	logic [7:0] ids [6] = '{IDX_CFG, IDX_EN, IDX_IGN, IDX_STAT, IDX_CLR, 8'hFF};
	logic [31:0] msk [3] = '{32'hFF, 32'hF, 32'hFF};
	int dly [$] = '{0, DA, DB, DC, DA};
	int err_total = 0, cmp_count = 0, cyc = 0, t, b0, b1;
	int regm [int];
	initial forever #2.5 mclk = ~mclk;
	supervisor_model sup (.mclk, .want, .pol, .power_on_request_in);
	power_good_debounce_polarity #(.DLY_A(DA), .DLY_B(DB), .DLY_C(DC)) dut (.mclk, .rst,
		.address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest,
		.power_on_request_in, .external_flag_in(ext), .supply_ok(!flt[0]),
		.ocp_fast_primary(flt[1]), .ocp_acc_primary(flt[2]), .ocp_acc_secondary(flt[3]),
		.uvp_fault(flt[4]), .ovp_local_fault(flt[5]), .ovp_load_fault(flt[6]),
		.power_good_primary_out(pg), .fault_flag_out(flag), .oring_transistor_out(gate),
		.irq);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
		address <= {idx, 2'b00};
		writedata <= d;
		read <= !wr;
		write <= wr;
		@(posedge mclk);
		while (waitrequest !== 1'b0) begin
			@(posedge mclk);
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [31:0] m);
		bus(1'b1, idx, d);
		regm[idx] = d & m;
	endtask
	task automatic rdc(input logic [7:0] idx);
		bus(1'b0, idx, 32'h0);
		check(rd, regm.exists(idx) ? regm[idx] : 0);
	endtask
	task automatic wait_pg(input logic v, output int n);
		n = 0;
		while (pg !== v && n < 300) begin
			@(posedge mclk);
			n++;
		end
		if (pg !== v) check(pg, v);
	endtask
	// supply held bad while polarity settles, so no stray power-good edge
	task automatic setcfg(input logic [7:0] c);
		flt[0] <= 1'b1;
		wr(IDX_CFG, c, 32'hFF);
		pol <= c[0];
		repeat (6) @(posedge mclk);
		flt[0] <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		foreach (ids[i]) rdc(ids[i]);
		foreach (msk[i]) begin
			wr(ids[i], xs(), msk[i]);
			rdc(ids[i]);
		end
		wr(8'hFF, xs(), 32'h0);
		rdc(8'hFF);
		byteenable <= 4'hE;
		bus(1'b1, IDX_EN, 32'h5);
		byteenable <= 4'hF;
		rdc(IDX_EN);
		$display("test registers done");
		// zero delay first: its latency is the fixed pipeline offset
		foreach (pats[i]) begin
			r = xs();
			setcfg({pats[i], 2'b00, r[1:0]});
			want <= 1'b1;
			wait_pg(1'b1, t);
			if (i == 0) b0 = t;
			check(t - b0, i == 0 ? 0 : dly[i] + 1);
			check(gate, !r[1]);
			want <= 1'b0;
			wait_pg(1'b0, t);
			if (i == 0) b1 = t;
			check(t - b1, i == 0 ? 0 : dly[i] + 1);
			check(gate, r[1]);
		end
		$display("test delays done");
		setcfg(8'hF0);
		want <= 1'b1;
		wait_pg(1'b1, t);
		bus(1'b0, IDX_LIVE, 32'h0);
		check(rd, 32'h0D);
		wr(IDX_CLR, 32'hF, 32'h0);
		wr(IDX_EN, 32'h8, 32'hF);
		r = xs() % 7;
		flt[r[2:0]] <= 1'b1;
		repeat (2) @(posedge mclk);
		check(pg, 0);
		repeat (2) @(posedge mclk);
		check(irq, 1);
		bus(1'b0, IDX_STAT, 32'h0);
		check(rd[3], 1);
		wr(IDX_EN, 32'h0, 32'hF);
		repeat (2) @(posedge mclk);
		check(irq, 0);
		wr(IDX_EN, 32'h8, 32'hF);
		repeat (2) @(posedge mclk);
		check(irq, 1);
		flt <= 7'h0;
		wr(IDX_CLR, 32'h8, 32'h0);
		repeat (2) @(posedge mclk);
		check(irq, 0);
		$display("test fault done");
		want <= 1'b0;
		wr(IDX_IGN, 32'h80, 32'hFF);
		for (int j = 0; j < 4; j++) begin
			wr(IDX_CFG, {j[1:0], 2'b00}, 32'hFF);
			ext <= !j[0];
			repeat (6) @(posedge mclk);
			check(flag, !j[1]);
			ext <= j[0];
			repeat (6) @(posedge mclk);
			check(flag, 0);
		end
		bus(1'b0, IDX_STAT, 32'h0);
		check(rd, 32'h7);
		$display("test flag done");
		results();
	end
endmodule // power_good_debounce_polarity_test
